// ### include/ssp_pkg.sv
// package: register map, field layout, reset values and state types of the serial slave port
package ssp_pkg;

   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [7:0] OFS_MODE = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_DATA = 8'h08;
   localparam logic [7:0] OFS_ADDR = 8'h0c;
   localparam logic [7:0] OFS_TMO = 8'h10;
   localparam logic [7:0] OFS_PULL = 8'h14;

   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] RST_MODE = 8'he0;
   localparam logic [7:0] RST_STAT = 8'h81;
   localparam logic [7:0] RST_DATA = 8'h00;
   localparam logic [7:0] RST_ADDR = 8'h00;
   localparam logic [7:0] RST_TMO = 8'h00;
   localparam logic [1:0] RST_PULL = 2'h0;

   // ****************************************
   // field positions and codes
   // ****************************************
   localparam int M_SEL_HI = 7;
   localparam int M_SEL_LO = 5;
   localparam int M_UART = 4;
   localparam int M_DEB_HI = 3;
   localparam int M_DEB_LO = 2;
   localparam int M_EN = 1;
   localparam int M_ICF = 0;
   localparam logic [2:0] MODE_SPI_SLAVE = 3'h5;
   localparam logic [2:0] MODE_I2C_SLAVE = 3'h6;
   localparam logic [1:0] DEB_OFF = 2'h0;
   localparam logic [1:0] DEB_SHORT = 2'h1;
   localparam logic [2:0] DEB_SHORT_CYC = 3'h2;
   localparam logic [2:0] DEB_LONG_CYC = 3'h4;
   localparam int S_HCF = 7;
   localparam int S_HAAS = 6;
   localparam int S_HBB = 5;
   localparam int S_TRANSMIT_ACK_SETTING = 3;
   localparam int S_SRW = 2;
   localparam int S_RXAK = 0;
   localparam logic [7:0] STAT_SW_MASK = 8'h1a;
   localparam int P_CKPOLB = 5;
   localparam int P_CKEG = 4;
   localparam int P_MLS = 3;
   localparam int P_SELECT_PIN_ENABLE = 2;
   localparam int P_WRITE_COLLISION_FLAG = 1;
   localparam int P_TRF = 0;
   localparam logic [2:0] LAST_BIT = 3'h7;

   // ****************************************
   // pin groups and state
   // ****************************************
   typedef struct packed {logic sck; logic sdi; logic scs_n;} spi_in_t;
   typedef struct packed {logic scl; logic sda;} i2c_in_t;
   typedef struct packed {
      logic scl_out; logic scl_oe_n; logic sda_out; logic sda_oe_n;
   } i2c_out_t;
   typedef struct packed {logic scl; logic sda;} pullup_t;

   typedef enum logic [2:0] {
      I_IDLE = 3'b000, I_ADDR = 3'b001, I_ACKA = 3'b010, I_RX = 3'b011,
      I_ACKR = 3'b100, I_TX = 3'b101, I_MACK = 3'b110
   } i2c_st_t;

   typedef struct packed {
      logic [7:0] mode; logic [7:0] stat; logic [7:0] data; logic [7:0] addr;
      logic [7:0] tmo; logic [1:0] pull;
      logic pend; logic pwr; logic [7:0] paddr; logic hrdy; logic [7:0] rdata;
      logic [4:0] sync1; logic [4:0] sync2;
      logic sck_p; logic [7:0] sh; logic [2:0] scnt; logic sdo;
      logic sclf; logic [2:0] dcnt; logic sda_p; i2c_st_t ist; logic [2:0] icnt;
      logic ack_on; logic drv_n;
   } state_t;

   localparam state_t ST_RST = '{mode: RST_MODE, stat: RST_STAT, data: RST_DATA,
      addr: RST_ADDR, tmo: RST_TMO, pull: RST_PULL, pend: 1'b0, pwr: 1'b0,
      paddr: 8'h00, hrdy: 1'b1, rdata: 8'h00, sync1: 5'h07, sync2: 5'h07,
      sck_p: 1'b0, sh: 8'h00, scnt: 3'h0, sdo: 1'b1, sclf: 1'b1, dcnt: 3'h0,
      sda_p: 1'b1, ist: I_IDLE, icnt: 3'h0, ack_on: 1'b0, drv_n: 1'b1};

endpackage

// ### verilog/serial_slave_port.sv
// serial slave port: SPI slave and two-wire slave behind an AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module serial_slave_port
   import ssp_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // spi pins
   input wire spi_in_t spi_i,
   output logic spi_sdo,
   // two-wire pins
   input wire i2c_in_t i2c_i,
   output i2c_out_t i2c_o,
   // pad pull-ups
   output pullup_t pullup_o
);

   // ****************************************
   // state
   // ****************************************
   state_t st_q;
   state_t st_d;

   logic en;
   logic spi_on;
   logic i2c_on;
   logic [7:0] wd;
   logic [7:0] rd;
   logic sck;
   logic sdi;
   logic scs_n;
   logic sel_ok;
   logic cap;
   logic scl_raw;
   logic sda;
   logic [2:0] dlen;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic [7:0] shin;
   logic bus_take;
   logic load_busy;

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      st_d = st_q;
      en = st_q.mode[M_EN] & ~st_q.mode[M_UART];
      spi_on = en & (st_q.mode[M_SEL_HI:M_SEL_LO] == MODE_SPI_SLAVE);
      i2c_on = en & (st_q.mode[M_SEL_HI:M_SEL_LO] == MODE_I2C_SLAVE);
      wd = hwdata[7:0];
      rd = 8'h00;
      sck = st_q.sync2[4];
      sdi = st_q.sync2[3];
      scs_n = st_q.sync2[2];
      scl_raw = st_q.sync2[1];
      sda = st_q.sync2[0];
      shin = 8'h00;
      bus_take = hsel & htrans[1] & hready;
      // a word is in flight once its first bit has been captured
      load_busy = spi_on & (st_q.scnt != 3'h0);

      // pins cross into hclk through two flops; every pin level must stand
      // for at least one hclk, and scl for dlen hclk with the filter on, or an edge of sck or scl is missed
      st_d.sync1 = {spi_i.sck, spi_i.sdi, spi_i.scs_n, i2c_i.scl, i2c_i.sda};
      st_d.sync2 = st_q.sync1;

      // bus: one wait state so read data leaves a flop
      // hrdata keeps the last read until the next one; writes leave it alone
      st_d.hrdy = 1'b1;
      if (st_q.pend) begin
         st_d.pend = 1'b0;
         unique case (st_q.paddr)
            OFS_MODE: rd = st_q.mode;
            OFS_STAT: rd = i2c_on ? st_q.stat : 8'h00;
            OFS_DATA: rd = st_q.data;
            OFS_ADDR: rd = st_q.addr;
            OFS_TMO: rd = i2c_on ? st_q.tmo : 8'h00;
            OFS_PULL: rd = {6'h00, st_q.pull};
            default: rd = 8'h00;
         endcase
         if (!st_q.pwr) begin
            st_d.rdata = rd;
         end else begin
            unique case (st_q.paddr)
               OFS_MODE: st_d.mode = wd;
               OFS_STAT: begin
                  if (i2c_on) begin
                     st_d.stat = (st_q.stat & ~STAT_SW_MASK) | (wd & STAT_SW_MASK);
                  end
               end
               OFS_DATA: begin
                  if (load_busy) begin
                     st_d.addr[P_WRITE_COLLISION_FLAG] = 1'b1;
                  end else begin
                     st_d.data = wd;
                     if (spi_on) begin
                        st_d.sh = wd;
                     end
                  end
               end
               OFS_ADDR: st_d.addr = wd;
               OFS_TMO: begin
                  if (i2c_on) begin
                     st_d.tmo = wd;
                  end
               end
               OFS_PULL: st_d.pull = wd[1:0];
               default: ;
            endcase
         end
      end else if (bus_take) begin
         st_d.pend = 1'b1;
         st_d.pwr = hwrite;
         st_d.paddr = haddr[7:0];
         st_d.hrdy = 1'b0;
      end

      // ****************************************
      // spi slave
      // ****************************************
      // hardware sets come after the bus write so a set beats a clear
      sel_ok = ~st_q.addr[P_SELECT_PIN_ENABLE] | ~scs_n;
      st_d.sck_p = sck;
      cap = (st_q.addr[P_CKPOLB] ^ st_q.addr[P_CKEG]) ? (~sck & st_q.sck_p)
                                                      : (sck & ~st_q.sck_p);
      if (spi_on) begin
         // select lifted mid-word: the partial word is dropped and flagged
         if (!sel_ok) begin
            if (st_q.scnt != 3'h0) begin
               st_d.mode[M_ICF] = 1'b1;
            end
            st_d.scnt = 3'h0;
         end else if (cap) begin
            // a load that lands with the first capture is the word that shifts
            shin = st_q.addr[P_MLS] ? {st_d.sh[6:0], sdi} : {sdi, st_d.sh[7:1]};
            st_d.sh = shin;
            st_d.scnt = st_q.scnt + 3'h1;
            if (st_q.scnt == LAST_BIT) begin
               st_d.data = shin;
               st_d.addr[P_TRF] = 1'b1;
            end
         end
         st_d.sdo = st_q.addr[P_MLS] ? st_d.sh[7] : st_d.sh[0];
      end else begin
         st_d.scnt = 3'h0;
         st_d.sdo = 1'b1;
      end

      // ****************************************
      // two-wire clock filter
      // ****************************************
      unique case (st_q.mode[M_DEB_HI:M_DEB_LO])
         DEB_OFF: dlen = 3'h0;
         DEB_SHORT: dlen = DEB_SHORT_CYC;
         default: dlen = DEB_LONG_CYC;
      endcase
      // a clock level must persist dlen cycles before it is believed
      // a glitch shorter than that restarts the count and never reaches sclf
      if (scl_raw == st_q.sclf) begin
         st_d.dcnt = 3'h0;
      end else if (st_q.dcnt + 3'h1 >= dlen) begin
         st_d.sclf = scl_raw;
         st_d.dcnt = 3'h0;
      end else begin
         st_d.dcnt = st_q.dcnt + 3'h1;
      end
      rise = st_d.sclf & ~st_q.sclf;
      fall = ~st_d.sclf & st_q.sclf;
      st_d.sda_p = sda;
      start = st_q.sclf & st_d.sclf & st_q.sda_p & ~sda;
      stop = st_q.sclf & st_d.sclf & ~st_q.sda_p & sda;
      shin = {st_q.sh[6:0], sda};

      // ****************************************
      // two-wire protocol
      // ****************************************
      if (!i2c_on) begin
         // hardware flags rest at power-on values while the mode is off, so
         // a fresh enable never shows a stale match or busy state
         st_d.stat = (st_q.stat & STAT_SW_MASK) | (RST_STAT & ~STAT_SW_MASK);
         st_d.icnt = 3'h0;
         st_d.ist = I_IDLE;
         st_d.drv_n = 1'b1;
         st_d.ack_on = 1'b0;
      end else if (start) begin
         st_d.ist = I_ADDR;
         st_d.icnt = 3'h0;
         st_d.stat[S_HBB] = 1'b1;
         st_d.stat[S_HAAS] = 1'b0;
         st_d.drv_n = 1'b1;
         st_d.ack_on = 1'b0;
      end else if (stop) begin
         st_d.ist = I_IDLE;
         st_d.stat[S_HBB] = 1'b0;
         st_d.stat[S_HAAS] = 1'b0;
         st_d.drv_n = 1'b1;
         st_d.ack_on = 1'b0;
      end else if (rise) begin
         unique case (st_q.ist)
            I_ADDR, I_RX: begin
               st_d.sh = shin;
               st_d.icnt = st_q.icnt + 3'h1;
               if (st_q.icnt == 3'h0) begin
                  st_d.stat[S_HCF] = 1'b0;
               end
               if (st_q.icnt == LAST_BIT) begin
                  st_d.stat[S_HCF] = 1'b1;
                  if (st_q.ist == I_RX) begin
                     st_d.data = shin;
                     st_d.ist = I_ACKR;
                  end else if (st_q.sh[6:0] == st_q.addr[7:1]) begin
                     st_d.stat[S_HAAS] = 1'b1;
                     // the eighth bit of the address byte is the direction
                     st_d.stat[S_SRW] = sda;
                     st_d.ist = I_ACKA;
                  end else begin
                     st_d.ist = I_IDLE;
                  end
               end
            end
            I_TX: begin
               if (st_q.icnt == 3'h0) begin
                  st_d.stat[S_HCF] = 1'b0;
               end
               st_d.sh = {st_q.sh[6:0], 1'b0};
               st_d.icnt = st_q.icnt + 3'h1;
               if (st_q.icnt == LAST_BIT) begin
                  st_d.stat[S_HCF] = 1'b1;
                  st_d.ist = I_MACK;
               end
            end
            I_MACK: begin
               // master's nack ends sending; the line is left for its stop
               st_d.stat[S_RXAK] = sda;
               st_d.icnt = 3'h0;
               st_d.sh = st_q.data;
               st_d.ist = sda ? I_IDLE : I_TX;
            end
            default: ;
         endcase
      end else if (fall) begin
         unique case (st_q.ist)
            I_ACKA, I_ACKR: begin
               // first fall after the eighth bit starts the acknowledge, the next ends it
               if (!st_q.ack_on) begin
                  st_d.ack_on = 1'b1;
                  st_d.drv_n = (st_q.ist == I_ACKA) ? 1'b0 : st_q.stat[S_TRANSMIT_ACK_SETTING];
               end else begin
                  st_d.ack_on = 1'b0;
                  st_d.icnt = 3'h0;
                  if (st_q.ist == I_ACKA && st_q.stat[S_SRW]) begin
                     st_d.ist = I_TX;
                     st_d.sh = st_q.data;
                     st_d.drv_n = st_q.data[7];
                  end else begin
                     st_d.ist = I_RX;
                     st_d.drv_n = 1'b1;
                  end
               end
            end
            // next bit goes out while scl is low
            I_TX: st_d.drv_n = st_q.sh[7];
            I_MACK: st_d.drv_n = 1'b1;
            default: ;
         endcase
      end
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign hreadyout = st_q.hrdy;
   assign hresp = 1'b0;
   assign hrdata = {24'h000000, st_q.rdata};
   assign spi_sdo = st_q.sdo;
   // both lines only ever pull low; the clock is never driven, so the slave
   // cannot stretch scl and software must keep pace with the master
   assign i2c_o = '{
      scl_out: 1'b0,
      scl_oe_n: 1'b1,
      sda_out: 1'b0,
      sda_oe_n: st_q.drv_n
   };
   assign pullup_o = '{scl: st_q.pull[1], sda: st_q.pull[0]};

endmodule // serial_slave_port

// ### testbench/serial_port_monitor.sv
// checker: bus timing and pin rules of the serial slave port
`timescale 1ns/1ps
module serial_port_monitor
   import ssp_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   // pins
   input wire spi_in_t spi_i,
   input wire logic spi_sdo,
   input wire i2c_out_t i2c_o,
   input wire pullup_t pullup_o
);
   // ****************************************
   // shadow of the bus side
   // ****************************************
   logic wr_q, rd_q;
   logic [7:0] ad_q, mode_q;
   wire take = hsel && htrans[1] && hready;
   wire fin = (wr_q || rd_q) && hreadyout;
   wire spi_on = mode_q[7:5] == MODE_SPI_SLAVE && mode_q[1] && !mode_q[4];
   wire i2c_on = mode_q[7:5] == MODE_I2C_SLAVE && mode_q[1] && !mode_q[4];
   // shadow lags the real register by one edge, hence the [*3] below
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         ad_q <= 8'h00;
         mode_q <= RST_MODE;
      end else begin
         if (fin && wr_q && ad_q == OFS_MODE)
            mode_q <= hwdata[7:0];
         if (take) begin
            wr_q <= hwrite;
            rd_q <= !hwrite;
            ad_q <= haddr[7:0];
         end else if (hreadyout) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
         end
      end
   end
   // ****************************************
   // properties
   // ****************************************
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   chk_wait_state: assert property (take |=> !hreadyout ##1 hreadyout)
      else $error("bus wait state missing");
   chk_scl_released: assert property (i2c_o.scl_oe_n)
      else $error("clock line driven");
   chk_sda_drain: assert property (!i2c_o.sda_out)
      else $error("data line driven high");
   chk_sdo_idle: assert property ((!spi_on) [*3] |-> spi_sdo)
      else $error("sdo not high outside spi slave mode");
   chk_sda_idle: assert property ((!i2c_on) [*3] |-> i2c_o.sda_oe_n)
      else $error("data line pulled outside two-wire mode");
   chk_pull_follow: assert property (fin && wr_q && ad_q == OFS_PULL |=>
      pullup_o == $past(hwdata[1:0]))
      else $error("pull-up outputs do not follow register");
   chk_read_byte: assert property (fin && rd_q |-> hrdata[31:8] == 24'h000000)
      else $error("upper read bits not zero");
   chk_mode_read: assert property (fin && rd_q && ad_q == OFS_MODE |->
      hrdata[7:1] == mode_q[7:1])
      else $error("mode read back wrong");
   chk_hidden_zero: assert property (fin && rd_q && (ad_q > OFS_PULL ||
      ad_q == OFS_STAT && !i2c_on) |-> hrdata == 32'h00000000)
      else $error("hidden or unmapped read not zero");
   cov_spi_frame: cover property (spi_on && !spi_i.scs_n);
   cov_ack_low: cover property (!i2c_o.sda_oe_n);
   cov_data_read: cover property (fin && rd_q && ad_q == OFS_DATA);
endmodule // serial_port_monitor

bind serial_slave_port serial_port_monitor mon (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .spi_i(spi_i), .spi_sdo(spi_sdo),
   .i2c_o(i2c_o), .pullup_o(pullup_o));

// ### testbench/serial_master_model.sv
// partner: external spi master and two-wire master driving the port pins
`timescale 1ns/1ps
module serial_master_model
   import ssp_pkg::*;
(
   // clock
   input wire logic clk,
   // spi side
   output spi_in_t spi_o,
   input wire logic sdo,
   // two-wire side, high means released
   output logic scl_rel,
   output logic sda_rel,
   input wire logic sda_line
);
   // quarter of the 160 ns link period
   task q;
      repeat (10) @(posedge clk);
   endtask
   initial begin
      spi_o = '{sck: 1'b0, sdi: 1'b0, scs_n: 1'b1};
      scl_rel = 1'b1;
      sda_rel = 1'b1;
   end
   // msb first, matching the slave setting; sck idles low, capture on rise
   task spi_xfer(input logic [7:0] tx, output logic [7:0] rx);
      spi_o.scs_n <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         spi_o.sdi <= tx[i];
         q;
         q;
         spi_o.sck <= 1'b1;
         rx[i] = sdo;
         q;
         q;
         spi_o.sck <= 1'b0;
      end
      q;
      q;
      spi_o.scs_n <= 1'b1;
      spi_o.sdi <= ~tx[0];
   endtask
   task i2c_start;
      sda_rel <= 1'b0;
      q;
      scl_rel <= 1'b0;
      q;
   endtask
   // sending 8'hff releases the line so the slave can transmit
   task i2c_byte(input logic [7:0] b, output logic [7:0] rb, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_rel <= b[i];
         q;
         scl_rel <= 1'b1;
         q;
         rb[i] = sda_line;
         q;
         scl_rel <= 1'b0;
         q;
      end
      sda_rel <= 1'b1;
      q;
      scl_rel <= 1'b1;
      q;
      ack = sda_line;
      q;
      scl_rel <= 1'b0;
      q;
   endtask
   task i2c_stop;
      sda_rel <= 1'b0;
      q;
      scl_rel <= 1'b1;
      q;
      sda_rel <= 1'b1;
      q;
   endtask
endmodule // serial_master_model

// ### testbench/tb_serial_slave_port.sv
// testbench: register, spi slave and two-wire slave scenarios of the serial port
`timescale 1ns/1ps
module tb_serial_slave_port
   import ssp_pkg::*;
;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, spi_sdo, scl_rel, sda_rel, ack;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] rx, rb;
   spi_in_t spi_i;
   i2c_in_t i2c_i;
   i2c_out_t i2c_o;
   pullup_t pullup_o;
   int err_count, comparisons;
   wire sda_line = sda_rel & (i2c_o.sda_oe_n | i2c_o.sda_out);
   wire scl_line = scl_rel & (i2c_o.scl_oe_n | i2c_o.scl_out);
   assign i2c_i = '{scl: scl_line, sda: sda_line};

   serial_slave_port dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .spi_i(spi_i),
      .spi_sdo(spi_sdo), .i2c_i(i2c_i), .i2c_o(i2c_o), .pullup_o(pullup_o));
   serial_master_model pm (.clk(hclk), .spi_o(spi_i), .sdo(spi_sdo), .scl_rel(scl_rel),
      .sda_rel(sda_rel), .sda_line(sda_line));

   // ****************************************
   // bus and compare tasks
   // ****************************************
   task cmp8(input string nm, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
      end
   endtask
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h000000, a};
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] r;
      ahb(1'b1, a, {24'h000000, d}, r);
   endtask
   task rchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
      logic [31:0] r;
      ahb(1'b0, a, 32'h00000000, r);
      cmp8(nm, e, r[7:0] & m);
   endtask
   task test_done;
      $display("mismatches %0d, comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   initial begin
      repeat (20000) @(posedge hclk);
      err_count++;
      test_done;
   end
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h00000000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h00000000;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rchk(OFS_MODE, 8'hff, RST_MODE, "mode_reset");
      rchk(OFS_ADDR, 8'hff, RST_ADDR, "addr_reset");
      rchk(OFS_STAT, 8'hff, 8'h00, "stat_hidden");
      rchk(8'h18, 8'hff, 8'h00, "unmapped");
      wr(OFS_PULL, 8'h03);
      rchk(OFS_PULL, 8'hff, 8'h03, "pullup");
      wr(OFS_MODE, {MODE_SPI_SLAVE, 5'b00010});
      wr(OFS_ADDR, 8'h3c);
      wr(OFS_DATA, 8'ha5);
      fork
         pm.spi_xfer(8'h3c, rx);
         begin
            repeat (100) @(posedge hclk);
            wr(OFS_DATA, 8'h11);
            rchk(OFS_DATA, 8'hff, 8'ha5, "spi_mid_word");
         end
      join
      cmp8("spi_sent", 8'ha5, rx);
      rchk(OFS_DATA, 8'hff, 8'h3c, "spi_received");
      rchk(OFS_ADDR, 8'hff, 8'h3f, "spi_flags");
      wr(OFS_ADDR, 8'h3c);
      rchk(OFS_ADDR, 8'hff, 8'h3c, "spi_flags_clear");
      wr(OFS_MODE, {MODE_I2C_SLAVE, 5'b00010});
      wr(OFS_ADDR, 8'h55);
      rchk(OFS_ADDR, 8'hff, 8'h55, "own_addr");
      pm.i2c_start;
      pm.i2c_byte(8'h56, rb, ack);
      pm.i2c_stop;
      cmp8("foreign_nack", 8'h01, {7'h00, ack});
      for (int d = 0; d < 3; d++) begin
         wr(OFS_MODE, {MODE_I2C_SLAVE, 1'b0, 2'(d), 2'b10});
         pm.i2c_start;
         pm.i2c_byte(8'h54, rb, ack);
         pm.i2c_stop;
         cmp8("addr_ack", 8'h00, {7'h00, ack});
      end
      pm.i2c_start;
      pm.i2c_byte(8'h54, rb, ack);
      rchk(OFS_STAT, 8'h44, 8'h40, "matched");
      pm.i2c_byte(8'h96, rb, ack);
      cmp8("rx_ack", 8'h00, {7'h00, ack});
      rchk(OFS_DATA, 8'hff, 8'h96, "i2c_received");
      rchk(OFS_STAT, 8'ha0, 8'ha0, "rx_done");
      wr(OFS_STAT, 8'h08);
      pm.i2c_byte(8'h33, rb, ack);
      cmp8("transmit_ack_setting_nack", 8'h01, {7'h00, ack});
      pm.i2c_stop;
      wr(OFS_STAT, 8'h00);
      wr(OFS_DATA, 8'hc3);
      pm.i2c_start;
      pm.i2c_byte(8'h55, rb, ack);
      rchk(OFS_STAT, 8'h04, 8'h04, "read_dir");
      pm.i2c_byte(8'hff, rb, ack);
      pm.i2c_stop;
      cmp8("i2c_sent", 8'hc3, rb);
      test_done;
   end
endmodule // tb_serial_slave_port
